//--- design/gpg_pkg.sv
// Shared constants for the GPIO port group controller.
// Assumes a 9-bit byte address: two group bits and a 128-byte register set.
package gpg_pkg;

    localparam int unsigned ADDR_W       = 9;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned PINS_PER_GRP = 32;
    localparam int unsigned MAX_GROUPS   = 4;
    localparam int unsigned SYNC_GRP_W   = 8;
    localparam int unsigned ROUTE_W      = 4;
    localparam int unsigned ROUTE_N      = 16;
    localparam int unsigned CFG_W        = 3;

    // Register set stride per group
    localparam logic [8:0] GROUP_STRIDE = 9'h080;

    // Word offsets inside one group's register set
    localparam logic [6:0] OFF_DIR    = 7'h00;
    localparam logic [6:0] OFF_DRIVE_OFF_MASK = 7'h04;
    localparam logic [6:0] OFF_DRIVE_ON_MASK = 7'h08;
    localparam logic [6:0] OFF_OUT    = 7'h10;
    localparam logic [6:0] OFF_LEVEL_LOW_MASK = 7'h14;
    localparam logic [6:0] OFF_LEVEL_HIGH_MASK = 7'h18;
    localparam logic [6:0] OFF_LEVEL_FLIP_MASK = 7'h1C;
    localparam logic [6:0] OFF_IN     = 7'h20;
    localparam logic [6:0] OFF_CTRL   = 7'h24;
    localparam logic [6:0] OFF_PMUX   = 7'h30;
    localparam logic [6:0] OFF_PINCFG = 7'h40;
    localparam int unsigned PMUX_BYTES   = 16;
    localparam int unsigned PINCFG_BYTES = 32;

    // Pad setup byte fields
    localparam int unsigned CFG_ALT_BIT  = 0;
    localparam int unsigned CFG_GATE_BIT = 1;
    localparam int unsigned CFG_PULL_BIT = 2;

    // Route select nibble positions
    localparam int unsigned EVEN_NIB_LSB = 0;
    localparam int unsigned ODD_NIB_LSB  = 4;

    // On-demand synchronizer clocking before an input read
    localparam logic [1:0] SYNC_CYCLES = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_ACK  = 3'h4
    } gpg_state_t;

endpackage

//--- design/gpg_port.sv
// GPIO port group controller: Wishbone registers, fast local path, pad control.
// Assumes pads and peripheral lines are synchronous to mclk; one clock domain.
// Notes on behaviour
// - Drive select bit one makes the pin an output, zero an input.
// - Output pins drive the pad at the level register value.
// - Sampled input readable in any direction, synchronized; zero when rx gate off.
// - On-demand synchronizers clock two cycles only for a read, delaying it three cycles.
// - Always-sync group bit keeps eight pins' synchronizers running; no delay only when all four bits are set.
// - Alt route on hands the pad to the selected peripheral line.
// - After reset pins are undriven, no pull, input buffer off.
// - Each 32-pin group has its own register set every 0x80 bytes.
// - Drive-on mask sets direction bits, drive-off mask clears them.
// - Level high, low and flip masks set, clear and invert level bits.
// - Each pin has its own pad setup byte at setup base plus pin.
// - Route selects packed two per byte; even pin low nibble, odd high.
// - Input, gate off, pull off: all digital pad functions disabled.
// - Input with pull: level bit zero pulls down, one pulls up.
// - Driving output disables pull; input buffer still follows its gate.
// - Fast path wins over Wishbone; Wishbone waits meanwhile.
`timescale 1ns/100ps
module gpg_port #(
    parameter int NUM_GROUPS = 1
) (
    input  wire logic                                         mclk,
    input  wire logic                                         rstn,
    input  wire logic                                         wb_cyc_i,
    input  wire logic                                         wb_stb_i,
    input  wire logic                                         wb_we_i,
    input  wire logic [gpg_pkg::ADDR_W-1:0]                   wb_adr_i,
    input  wire logic [3:0]                                   wb_sel_i,
    input  wire logic [gpg_pkg::DATA_W-1:0]                   wb_dat_i,
    output logic      [gpg_pkg::DATA_W-1:0]                   wb_dat_o,
    output logic                                              wb_ack_o,
    input  wire logic                                         fp_valid,
    input  wire logic                                         fp_we,
    input  wire logic [gpg_pkg::ADDR_W-1:0]                   fp_addr,
    input  wire logic [3:0]                                   fp_sel,
    input  wire logic [gpg_pkg::DATA_W-1:0]                   fp_wdata,
    output logic      [gpg_pkg::DATA_W-1:0]                   fp_rdata,
    input  wire logic [NUM_GROUPS*32-1:0]                     pad_in,
    output logic      [NUM_GROUPS*32-1:0]                     pad_out,
    output logic      [NUM_GROUPS*32-1:0]                     pad_oe,
    output logic      [NUM_GROUPS*32-1:0]                     pad_pull_en,
    output logic      [NUM_GROUPS*32-1:0]                     pad_pull_up,
    output logic      [NUM_GROUPS*32-1:0]                     pad_in_en,
    input  wire logic [NUM_GROUPS*32*gpg_pkg::ROUTE_N-1:0]    fn_out,
    input  wire logic [NUM_GROUPS*32*gpg_pkg::ROUTE_N-1:0]    fn_oe,
    output logic      [NUM_GROUPS*32-1:0]                     fn_in
);
    localparam int NP = NUM_GROUPS * 32;

    if (NUM_GROUPS < 1 || NUM_GROUPS > gpg_pkg::MAX_GROUPS) begin : g_bad_groups
        $error("gpg_port supports one to four pin groups");
    end

    typedef struct packed {
        logic [NUM_GROUPS-1:0][31:0]                        dir;
        logic [NUM_GROUPS-1:0][31:0]                        out;
        logic [NUM_GROUPS-1:0][31:0][gpg_pkg::CFG_W-1:0]    cfg;
        logic [NUM_GROUPS-1:0][31:0][gpg_pkg::ROUTE_W-1:0]  route;
        logic [NUM_GROUPS-1:0][3:0]                         samp;
        gpg_pkg::gpg_state_t                                st;
        logic [1:0]                                         cnt;
        logic [31:0]                                        wb_dat;
        logic                                               wb_ack;
        logic [31:0]                                        fp_dat;
        logic [NP-1:0]                                      p_out;
        logic [NP-1:0]                                      p_oe;
        logic [NP-1:0]                                      p_pen;
        logic [NP-1:0]                                      p_pup;
        logic [NP-1:0]                                      p_ien;
        logic [NP-1:0]                                      p_fin;
    } gpg_regs_t;

    gpg_regs_t             q;
    gpg_regs_t             d;
    logic [NP-1:0]         sync_in;
    logic [NP-1:0]         sync_q;
    logic [NP/8-1:0]       sync_en;
    logic [NP-1:0]         nxt_out;
    logic [NP-1:0]         nxt_oe;
    logic [NP-1:0]         nxt_pen;
    logic [NP-1:0]         nxt_pup;
    logic [NP-1:0]         nxt_ien;
    logic                  wb_req;
    logic                  demand;
    logic                  demand_start;
    logic                  plain_start;
    logic                  acc_we;
    logic [8:0]            acc_adr;
    logic [31:0]           acc_m;
    logic [31:0]           acc_wd;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic in_range(input logic [6:0] off, input logic [6:0] base,
                                      input int unsigned bytes);
        return (int'(off) >= int'(base)) && (int'(off) < int'(base) + int'(bytes));
    endfunction

    function automatic gpg_regs_t reg_write(input gpg_regs_t r, input logic [8:0] a,
                                           input logic [31:0] m, input logic [31:0] wd);
        int          g;
        int          k;
        logic [6:0]  off;
        logic [31:0] wm;
        g   = int'(a[8:7]);
        off = {a[6:2], 2'b00};
        wm  = wd & m;
        if (g < NUM_GROUPS) begin
            case (off)
                gpg_pkg::OFF_DIR:    r.dir[g] = (r.dir[g] & ~m) | wm;
                gpg_pkg::OFF_DRIVE_OFF_MASK: r.dir[g] = r.dir[g] & ~wm;
                gpg_pkg::OFF_DRIVE_ON_MASK: r.dir[g] = r.dir[g] | wm;
                gpg_pkg::OFF_OUT:    r.out[g] = (r.out[g] & ~m) | wm;
                gpg_pkg::OFF_LEVEL_LOW_MASK: r.out[g] = r.out[g] & ~wm;
                gpg_pkg::OFF_LEVEL_HIGH_MASK: r.out[g] = r.out[g] | wm;
                gpg_pkg::OFF_LEVEL_FLIP_MASK: r.out[g] = r.out[g] ^ wm;
                gpg_pkg::OFF_CTRL: begin
                    if (m[0]) begin
                        r.samp[g] = wd[3:0];
                    end
                end
                default: begin
                    for (int l = 0; l < 4; l++) begin
                        if (m[8*l] && in_range(off, gpg_pkg::OFF_PMUX, gpg_pkg::PMUX_BYTES)) begin
                            k = (int'(off) - int'(gpg_pkg::OFF_PMUX)) + l;
                            r.route[g][2*k]   = wd[8*l+gpg_pkg::EVEN_NIB_LSB +: 4];
                            r.route[g][2*k+1] = wd[8*l+gpg_pkg::ODD_NIB_LSB +: 4];
                        end
                        if (m[8*l] && in_range(off, gpg_pkg::OFF_PINCFG,
                                               gpg_pkg::PINCFG_BYTES)) begin
                            k = (int'(off) - int'(gpg_pkg::OFF_PINCFG)) + l;
                            r.cfg[g][k] = wd[8*l +: gpg_pkg::CFG_W];
                        end
                    end
                end
            endcase
        end
        return r;
    endfunction

    function automatic logic [31:0] reg_read(input gpg_regs_t r, input logic [8:0] a,
                                             input logic [NP-1:0] s);
        int          g;
        int          k;
        logic [6:0]  off;
        logic [31:0] v;
        v   = '0;
        g   = int'(a[8:7]);
        off = {a[6:2], 2'b00};
        if (g < NUM_GROUPS) begin
            case (off)
                gpg_pkg::OFF_DIR, gpg_pkg::OFF_DRIVE_OFF_MASK, gpg_pkg::OFF_DRIVE_ON_MASK: v = r.dir[g];
                gpg_pkg::OFF_OUT, gpg_pkg::OFF_LEVEL_LOW_MASK,
                gpg_pkg::OFF_LEVEL_HIGH_MASK, gpg_pkg::OFF_LEVEL_FLIP_MASK: v = r.out[g];
                gpg_pkg::OFF_IN:   v = s[g*32 +: 32];
                gpg_pkg::OFF_CTRL: v[3:0] = r.samp[g];
                default: begin
                    for (int l = 0; l < 4; l++) begin
                        if (in_range(off, gpg_pkg::OFF_PMUX, gpg_pkg::PMUX_BYTES)) begin
                            k = (int'(off) - int'(gpg_pkg::OFF_PMUX)) + l;
                            v[8*l+gpg_pkg::EVEN_NIB_LSB +: 4] = r.route[g][2*k];
                            v[8*l+gpg_pkg::ODD_NIB_LSB +: 4]  = r.route[g][2*k+1];
                        end
                        if (in_range(off, gpg_pkg::OFF_PINCFG, gpg_pkg::PINCFG_BYTES)) begin
                            k = (int'(off) - int'(gpg_pkg::OFF_PINCFG)) + l;
                            v[8*l +: gpg_pkg::CFG_W] = r.cfg[g][k];
                        end
                    end
                end
            endcase
        end
        return v;
    endfunction

    // Per-pin pad control and input gating
    for (genvar i = 0; i < NP; i++) begin : g_pin
        localparam int G = i / 32;
        localparam int B = i % 32;
        logic       alt;
        logic [3:0] rsel;
        assign alt        = q.cfg[G][B][gpg_pkg::CFG_ALT_BIT];
        assign rsel       = q.route[G][B];
        assign sync_in[i] = pad_in[i] & q.cfg[G][B][gpg_pkg::CFG_GATE_BIT];
        assign nxt_oe[i]  = alt ? fn_oe[i*gpg_pkg::ROUTE_N + int'(rsel)] : q.dir[G][B];
        assign nxt_out[i] = alt ? fn_out[i*gpg_pkg::ROUTE_N + int'(rsel)] : q.out[G][B];
        // Pull only while not driving, level picks up or down
        assign nxt_pen[i] = ~alt & ~q.dir[G][B] & q.cfg[G][B][gpg_pkg::CFG_PULL_BIT];
        assign nxt_pup[i] = nxt_pen[i] & q.out[G][B];
        assign nxt_ien[i] = alt | q.cfg[G][B][gpg_pkg::CFG_GATE_BIT];
    end

    // Synchronizer clocking: always-on groups or an outstanding demand read
    for (genvar n = 0; n < NP/8; n++) begin : g_samp
        assign sync_en[n] = q.samp[n/4][n%4]
                          | ((q.st == gpg_pkg::ST_WAIT) && (q.cnt != 2'h0)
                             && (int'(wb_adr_i[8:7]) == n/4));
    end

    gpg_sync #(
        .WIDTH (NP)
    ) u_sync (
        .mclk  (mclk),
        .rstn  (rstn),
        .d_in  (sync_in),
        .en    (sync_en),
        .q_out (sync_q)
    );

    assign wb_req = wb_cyc_i && wb_stb_i && (q.st == gpg_pkg::ST_IDLE) && !fp_valid;
    assign demand = !wb_we_i && ({wb_adr_i[6:2], 2'b00} == gpg_pkg::OFF_IN)
                  && (int'(wb_adr_i[8:7]) < NUM_GROUPS) && !(&q.samp[wb_adr_i[8:7]]);
    assign demand_start = wb_req && demand;
    assign plain_start  = wb_req && !demand;
    assign acc_we  = fp_valid ? fp_we : (plain_start && wb_we_i);
    assign acc_adr = fp_valid ? fp_addr : wb_adr_i;
    assign acc_m   = lane_mask(fp_valid ? fp_sel : wb_sel_i);
    assign acc_wd  = fp_valid ? fp_wdata : wb_dat_i;

    always_comb begin
        d        = q;
        d.wb_ack = 1'b0;
        d.p_out  = nxt_out;
        d.p_oe   = nxt_oe;
        d.p_pen  = nxt_pen;
        d.p_pup  = nxt_pup;
        d.p_ien  = nxt_ien;
        d.p_fin  = pad_in;
        if (acc_we) begin
            d = reg_write(d, acc_adr, acc_m, acc_wd);
        end
        if (fp_valid) begin
            d.fp_dat = reg_read(q, fp_addr, sync_q);
        end
        case (q.st)
            gpg_pkg::ST_IDLE: begin
                if (demand_start) begin
                    d.st  = gpg_pkg::ST_WAIT;
                    d.cnt = gpg_pkg::SYNC_CYCLES;
                end else if (plain_start) begin
                    d.wb_dat = reg_read(q, wb_adr_i, sync_q);
                    d.wb_ack = 1'b1;
                    d.st     = gpg_pkg::ST_ACK;
                end
            end
            gpg_pkg::ST_WAIT: begin
                if (q.cnt != 2'h0) begin
                    d.cnt = q.cnt - 2'h1;
                end else begin
                    d.wb_dat = reg_read(q, wb_adr_i, sync_q);
                    d.wb_ack = 1'b1;
                    d.st     = gpg_pkg::ST_ACK;
                end
            end
            gpg_pkg::ST_ACK: d.st = gpg_pkg::ST_IDLE;
            default:         d.st = gpg_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q    <= '0;
            q.st <= gpg_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o    = q.wb_dat;
    assign wb_ack_o    = q.wb_ack;
    assign fp_rdata    = q.fp_dat;
    assign pad_out     = q.p_out;
    assign pad_oe      = q.p_oe;
    assign pad_pull_en = q.p_pen;
    assign pad_pull_up = q.p_pup;
    assign pad_in_en   = q.p_ien;
    assign fn_in       = q.p_fin;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence ack_after_sync_s;
        ##1 !wb_ack_o [*3] ##1 wb_ack_o;
    endsequence

    dir_drives_pad_a: assert property (!q.cfg[0][0][gpg_pkg::CFG_ALT_BIT] |=>
        pad_oe[0] == $past(q.dir[0][0]))
        else $error("pad enable does not follow direction");
    level_drives_pad_a: assert property (!q.cfg[0][0][gpg_pkg::CFG_ALT_BIT] |=>
        pad_out[0] == $past(q.out[0][0]))
        else $error("pad level does not follow level bit");
    gate_blocks_in_a: assert property ((!q.cfg[0][0][gpg_pkg::CFG_GATE_BIT] && q.samp[0][0])
        [*3] |-> !sync_q[0])
        else $error("sample seen with rx gate off");
    demand_delay_a: assert property (demand_start |-> ack_after_sync_s)
        else $error("demand read not delayed by two sync cycles");
    plain_ack_a: assert property (plain_start |=> wb_ack_o ##1 !wb_ack_o)
        else $error("plain access not answered next cycle");
    alt_route_a: assert property (q.cfg[0][0][gpg_pkg::CFG_ALT_BIT] |=>
        pad_out[0] == $past(fn_out[int'(q.route[0][0])]) && !pad_pull_en[0])
        else $error("alt route line not on pad");
    reset_quiet_a: assert property ($past(!rstn) |->
        pad_oe == '0 && pad_pull_en == '0 && pad_in_en == '0)
        else $error("pads active after reset");
    drive_on_a: assert property (acc_we && acc_adr == {2'b00, gpg_pkg::OFF_DRIVE_ON_MASK} |=>
        q.dir[0] == ($past(q.dir[0]) | $past(acc_wd & acc_m)))
        else $error("drive-on mask misapplied");
    level_flip_a: assert property (acc_we && acc_adr == {2'b00, gpg_pkg::OFF_LEVEL_FLIP_MASK} |=>
        q.out[0] == ($past(q.out[0]) ^ $past(acc_wd & acc_m)))
        else $error("level flip mask misapplied");
    pull_off_drive_a: assert property (pad_oe[0] && !q.cfg[0][0][gpg_pkg::CFG_ALT_BIT] |->
        !pad_pull_en[0])
        else $error("pull left on while driving");
    pull_dir_a: assert property (!q.cfg[0][0][gpg_pkg::CFG_ALT_BIT] && !q.dir[0][0]
        && q.cfg[0][0][gpg_pkg::CFG_PULL_BIT] |=> pad_pull_en[0]
        && pad_pull_up[0] == $past(q.out[0][0]))
        else $error("pull direction wrong");
    fast_priority_a: assert property (fp_valid && q.st == gpg_pkg::ST_IDLE |=> !wb_ack_o)
        else $error("bus answered during fast path access");

endmodule // gpg_port

//--- design/gpg_sync.sv
// Two-stage input synchronizers, clocked per group of eight bits.
// Assumes the enable comes from registered logic in the same clock domain.
`timescale 1ns/100ps
module gpg_sync #(
    parameter int WIDTH = 32
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic [WIDTH-1:0]   d_in,
    input  wire logic [WIDTH/8-1:0] en,
    output logic      [WIDTH-1:0]   q_out
);
    if (WIDTH < 8 || (WIDTH % 8) != 0) begin : g_bad_width
        $error("gpg_sync width must be a multiple of eight");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gpg_sync_t;

    gpg_sync_t        q;
    gpg_sync_t        d;
    logic [WIDTH-1:0] bit_en;

    for (genvar i = 0; i < WIDTH; i++) begin : g_en
        assign bit_en[i] = en[i / gpg_pkg::SYNC_GRP_W];
    end

    // Stage 1 feeds stage 2 only
    always_comb begin
        d = q;
        d.stage1 = (d_in & bit_en) | (q.stage1 & ~bit_en);
        d.stage2 = (q.stage1 & bit_en) | (q.stage2 & ~bit_en);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign q_out = q.stage2;

endmodule // gpg_sync

//--- sim/gpg_pad_model.sv
// Pad and peripheral-line model facing the port group controller.
// Assumes pad controls are registered in the mclk domain.
`timescale 1ns/100ps
module gpg_pad_model #(
    parameter int NP = 64
) (
    input  wire logic             mclk,
    input  wire logic [NP-1:0]    pad_out,
    input  wire logic [NP-1:0]    pad_oe,
    input  wire logic [NP-1:0]    pad_pull_en,
    input  wire logic [NP-1:0]    pad_pull_up,
    output logic      [NP-1:0]    pad_in,
    output logic      [NP*16-1:0] fn_out,
    output logic      [NP*16-1:0] fn_oe
);
    logic [NP-1:0] float_q = '0;
    // Undriven, unpulled pads wander every cycle
    always_ff @(posedge mclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i]
                      : pad_pull_en[i] ? pad_pull_up[i] : float_q[i];
            for (int s = 0; s < 16; s++) begin
                fn_oe[i*16+s]  = s[0];
                fn_out[i*16+s] = s[1];
            end
        end
    end
endmodule // gpg_pad_model

//--- sim/tb.sv
// Self-checking bench: Wishbone and fast path against a bit model.
// Assumes two port groups and the pad model looping pads back.
`timescale 1ns/100ps
module tb;
    logic        mclk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, fv = 0, fwe = 0;
    logic [8:0]  adr = '0, fa = '0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wd = '0, fd = '0, wb_dat_o, fp_rdata, r, m;
    logic        wb_ack_o;
    logic [63:0] pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, pad_in_en, fn_in;
    logic [1023:0] fn_out, fn_oe;
    logic [31:0] dir[2], out[2], gate[2], pull[2];
    logic [31:0] seed = 32'h0001_33C1;
    logic [6:0]  offs[7];
    logic [1:0]  g;
    int          n, n_errors = 0, n_tests = 0;

    gpg_port #(.NUM_GROUPS(2)) gpg_port_i (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fp_valid(fv), .fp_we(fwe), .fp_addr(fa),
        .fp_sel(sel), .fp_wdata(fd), .fp_rdata(fp_rdata), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up),
        .pad_in_en(pad_in_en), .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fn_in));
    gpg_pad_model #(.NP(64)) gpg_pad_model_i (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up), .pad_in(pad_in),
        .fn_out(fn_out), .fn_oe(fn_oe));

    initial begin
        forever #4 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Classic cycle; n counts edges until ack is seen
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
        end
        r = wb_dat_o;
        cyc <= 0; stb <= 0;
        @(posedge mclk);
    endtask
    task automatic fp(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        fv <= 1; fwe <= w; fa <= a; fd <= d;
    endtask
    task automatic pads();
        logic [63:0] d, o, pe;
        d  = {dir[1], dir[0]};
        o  = {out[1], out[0]};
        pe = {pull[1], pull[0]} & ~d;
        repeat (2) @(posedge mclk);
        chk("pad_oe", pad_oe, d);
        chk("pad_out", pad_out & d, o & d);
        chk("pad_pull_en", pad_pull_en, pe);
        chk("pad_pull_up", pad_pull_up, pe & o);
        chk("pad_in_en", pad_in_en, {gate[1], gate[0]});
        chk("fn_in", fn_in & d, o & d);
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        end_sim();
    end

    initial begin
        offs = '{gpg_pkg::OFF_DIR, gpg_pkg::OFF_DRIVE_OFF_MASK, gpg_pkg::OFF_DRIVE_ON_MASK, gpg_pkg::OFF_OUT,
                 gpg_pkg::OFF_LEVEL_LOW_MASK, gpg_pkg::OFF_LEVEL_HIGH_MASK, gpg_pkg::OFF_LEVEL_FLIP_MASK};
        dir = '{2{'0}}; out = '{2{'0}}; gate = '{2{'0}}; pull = '{2{'0}};
        repeat (16) @(posedge mclk);
        rstn <= 1;
        chk("reset pads", pad_oe | pad_pull_en | pad_in_en, '0);
        pads();
        for (int k = 0; k < 14; k++) begin
            g = 2'(rnd() % 2);
            m = rnd();
            wb(1, {g, offs[k%7]}, m);
            case (k % 7)
                0: dir[g] = m;
                1: dir[g] &= ~m;
                2: dir[g] |= m;
                3: out[g] = m;
                4: out[g] &= ~m;
                5: out[g] |= m;
                default: out[g] ^= m;
            endcase
            wb(0, {g, gpg_pkg::OFF_DIR}, '0);
            chk("dir", r, dir[g]);
            wb(0, {g, gpg_pkg::OFF_OUT}, '0);
            chk("out", r, out[g]);
            pads();
        end
        for (int w = 0; w < 16; w++) begin
            g = 2'(w / 8);
            m = rnd() & 32'h0606_0606;
            wb(1, {g, gpg_pkg::OFF_PINCFG + 7'((w % 8) * 4)}, m);
            for (int b = 0; b < 4; b++) begin
                gate[g][(w%8)*4+b] = m[8*b+1];
                pull[g][(w%8)*4+b] = m[8*b+2];
            end
        end
        pads();
        for (int q = 0; q < 2; q++) begin
            wb(0, {q[1:0], gpg_pkg::OFF_IN}, '0);
            chk("in delay", 64'(n), 64'd5);
            m = ~gate[q] | dir[q] | pull[q];
            chk("in", r & m, gate[q] & out[q] & m);
            wb(1, {q[1:0], gpg_pkg::OFF_CTRL}, 32'h0000_000F);
            wb(0, {q[1:0], gpg_pkg::OFF_IN}, '0);
            chk("in sync", 64'(n), 64'd2);
        end
        fork
            wb(0, {2'h0, gpg_pkg::OFF_DIR}, '0);
            begin
                for (int k = 0; k < 4; k++) begin
                    m = rnd();
                    out[0] |= m;
                    fp(1, {2'h0, gpg_pkg::OFF_LEVEL_HIGH_MASK}, m);
                end
                @(posedge mclk);
                fv <= 0;
            end
        join
        chk("wb held", 64'(n), 64'd6);
        chk("dir held", r, dir[0]);
        fp(0, {2'h0, gpg_pkg::OFF_OUT}, '0);
        @(posedge mclk);
        fv <= 0;
        @(posedge mclk);
        chk("fp out", fp_rdata, out[0]);
        fp(0, {2'h0, gpg_pkg::OFF_IN}, '0);
        @(posedge mclk);
        fv <= 0;
        @(posedge mclk);
        m = ~gate[0] | dir[0] | pull[0];
        chk("fp in", fp_rdata & m, gate[0] & out[0] & m);
        wb(1, {2'h0, gpg_pkg::OFF_PMUX}, 32'h0000_1221);
        wb(1, {2'h0, gpg_pkg::OFF_PINCFG}, 32'h0303_0303);
        repeat (2) @(posedge mclk);
        chk("alt oe", pad_oe[3:0], 4'h9);
        chk("alt out", pad_out[3:0], 4'h6);
        chk("alt pull", pad_pull_en[3:0], 4'h0);
        wb(0, 9'h100, '0);
        chk("unmapped", r, '0);
        end_sim();
    end
endmodule // tb
